// ---- rtl/smh_pkg.sv ----
// package of constants and types for the serial modem handshake controller
package smh_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [3:0] ADDR_MODE      = 4'h0;
	localparam logic [3:0] ADDR_CCR_TWO   = 4'h1;
	localparam logic [3:0] ADDR_TXBC_HIGH = 4'h2;
	localparam logic [3:0] ADDR_CFG       = 4'h3;
	localparam logic [3:0] ADDR_IRQ_STAT  = 4'h4;
	localparam logic [3:0] ADDR_IRQ_MASK  = 4'h5;
	localparam logic [3:0] ADDR_STATUS    = 4'h6;
	// ****************************************
	// field positions
	// ****************************************
	localparam int MODE_RAC_BIT  = 3;
	localparam int MODE_RTS_BIT  = 2;
	localparam int MODE_RLVL_BIT = 1;
	localparam int MODE_TLP_BIT  = 0;
	localparam int CHANNEL_CONTROL_TWO_SOC1_BIT = 7;
	localparam int CHANNEL_CONTROL_TWO_SOC0_BIT = 6;
	localparam int TXBC_CAS_BIT  = 2;
	localparam int TXBC_DMA_BIT  = 7;
	localparam int CFG_BUS_BIT   = 7;
	localparam int CFG_PU_BIT    = 6;
	localparam int IRQ_CSC_BIT   = 1;
	localparam int IRQ_XMR_BIT   = 0;
	// ****************************************
	// reset values and SOC field codes
	// ****************************************
	localparam logic [7:0] MODE_RST     = 8'h00;
	localparam logic [7:0] CHANNEL_CONTROL_TWO_RST     = 8'h00;
	localparam logic [7:0] TXBC_RST     = 8'h00;
	localparam logic [7:0] CFG_RST      = 8'h00;
	localparam logic [7:0] IRQ_MASK_RST = 8'hff;
	localparam logic [1:0] SOC_RX_ACT   = 2'h3;
	localparam logic [1:0] SOC_OFF      = 2'h2;
	// ****************************************
	// protocols and clock modes
	// ****************************************
	localparam logic [1:0] PROTO_HDLC  = 2'h0;
	localparam logic [1:0] PROTO_ASYNC = 2'h1;
	localparam logic [1:0] PROTO_BSYNC = 2'h2;
	localparam logic [2:0] CLK_MODE_0  = 3'h0;
	localparam logic [2:0] CLK_MODE_1  = 3'h1;
	localparam logic [2:0] CLK_MODE_5  = 3'h5;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ       = 25;
	localparam int RESET_MIN_US  = 5;
	localparam int RESET_MIN_CYC = RESET_MIN_US * CLK_MHZ;
	// ****************************************
	// transmit gate states
	// ****************************************
	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_SEND  = 2'b01,
		TX_ABORT = 2'b11,
		TX_DRAIN = 2'b10
	} smh_tx_state_t;
endpackage

// ---- rtl/smh_sync.sv ----
// two flip-flop synchroniser for a pin input
`timescale 1ns/10ps
module smh_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic din,
	output logic      dout
);
	typedef struct packed {
		logic s1;
		logic s2;
	} smh_sync_st_t;
	smh_sync_st_t st_reg;
	smh_sync_st_t st_next;

	always_comb begin
		st_next    = st_reg;
		st_next.s1 = din;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_reg <= '{s1: RST_VAL, s2: RST_VAL};
		end else begin
			st_reg <= st_next;
		end
	end

	assign dout = st_reg.s2;
endmodule // smh_sync

// ---- rtl/smh_edge.sv ----
// edge detector for an already synchronised level
`timescale 1ns/10ps
module smh_edge (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic lvl,
	output logic      any_edge
);
	typedef struct packed {
		logic last;
	} smh_edge_st_t;
	smh_edge_st_t st_reg;
	smh_edge_st_t st_next;

	always_comb begin
		st_next      = st_reg;
		st_next.last = lvl;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_reg <= '{last: 1'b1};
		end else begin
			st_reg <= st_next;
		end
	end

	assign any_edge = lvl ^ st_reg.last;
endmodule // smh_edge

// ---- rtl/smh_ctrl.sv ----
// modem handshake control of one serial channel
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module smh_ctrl #(
	parameter int RESET_CYC = smh_pkg::RESET_MIN_CYC
) (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// register port
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// modem pins
	output logic            rts_n,
	input  wire logic       cts_n,
	input  wire logic       cd,
	// transmitter side
	input  wire logic       tx_req,
	input  wire logic       tx_char_end,
	input  wire logic       tx_frame_end,
	input  wire logic       tx_pool_released,
	input  wire logic       tx_frame_held,
	input  wire logic       tx_serial,
	output logic            tx_enable,
	output logic            tx_restart,
	output logic            tx_fifo_reset,
	output logic            tx_idle_ones,
	output logic            txd_out,
	// receiver side
	input  wire logic       rx_frame_active,
	input  wire logic       rx_byte_end,
	input  wire logic       rxd_pin,
	output logic            rxd_core,
	output logic            rx_enable,
	// channel settings
	input  wire logic [1:0] protocol,
	input  wire logic [2:0] clock_mode,
	output logic            power_down,
	output logic            irq
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [7:0]            mode;
		logic [7:0]            channel_control_two;
		logic [7:0]            txbc;
		logic [7:0]            cfg;
		logic [1:0]            irq_stat;
		logic [7:0]            irq_mask;
		logic [7:0]            rdata;
		smh_pkg::smh_tx_state_t tx_st;
		logic                  pool_gone;
		logic                  rx_on;
		logic                  rts_n;
		logic                  tx_enable;
		logic                  tx_restart;
		logic                  tx_fifo_reset;
		logic                  idle_ones;
		logic                  txd;
		logic                  rxd;
		logic                  rts_hold;
		logic                  pdn;
		logic                  irq;
	} smh_ctrl_st_t;

	smh_ctrl_st_t st_reg;
	smh_ctrl_st_t st_next;
	logic         cts_ok;
	logic         cd_s;
	logic         cts_s;
	logic         cts_edge;

	// ****************************************
	// elaboration checks
	// ****************************************
	if (RESET_CYC < 1) begin : g_bad_reset
		$error("reset count must be at least one cycle");
	end

	// ****************************************
	// functions
	// ****************************************
	function automatic logic sync_proto(input logic [1:0] p);
		return (p == smh_pkg::PROTO_HDLC) || (p == smh_pkg::PROTO_BSYNC);
	endfunction

	function automatic logic special_active(
		input logic       bus_cfg,
		input logic [2:0] cm
	);
		return bus_cfg && (cm == smh_pkg::CLK_MODE_0 || cm == smh_pkg::CLK_MODE_1);
	endfunction

	function automatic logic autostart_ok(
		input logic       cas,
		input logic [2:0] cm
	);
		return cas && cm != smh_pkg::CLK_MODE_1 && cm != smh_pkg::CLK_MODE_5;
	endfunction

	// ****************************************
	// input synchronisers
	// ****************************************
	smh_sync #(.RST_VAL(1'b1)) u_cts_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     (cts_n),
		.dout    (cts_s)
	);
	smh_sync #(.RST_VAL(1'b0)) u_cd_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     (cd),
		.dout    (cd_s)
	);
	smh_edge u_cts_edge (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.lvl      (cts_s),
		.any_edge (cts_edge)
	);
	assign cts_ok = !cts_s;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic       special;
		logic [1:0] soc;
		logic       cas_ok;
		logic       req_pend;
		special  = 1'b0;
		soc      = 2'h0;
		cas_ok   = 1'b0;
		req_pend = 1'b0;
		st_next  = st_reg;
		st_next.tx_restart    = 1'b0;
		st_next.tx_fifo_reset = 1'b0;

		// register writes
		if (reg_wr) begin
			case (reg_addr)
				smh_pkg::ADDR_MODE: begin
					st_next.mode = reg_wdata;
				end
				smh_pkg::ADDR_CCR_TWO: begin
					st_next.channel_control_two = reg_wdata;
				end
				smh_pkg::ADDR_TXBC_HIGH: begin
					st_next.txbc = reg_wdata;
				end
				smh_pkg::ADDR_CFG: begin
					st_next.cfg = reg_wdata;
				end
				smh_pkg::ADDR_IRQ_STAT: begin
					st_next.irq_stat = st_reg.irq_stat & ~reg_wdata[1:0];
				end
				smh_pkg::ADDR_IRQ_MASK: begin
					st_next.irq_mask = reg_wdata;
				end
				default: begin
				end
			endcase
		end

		// register reads
		st_next.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				smh_pkg::ADDR_MODE:      st_next.rdata = st_reg.mode;
				smh_pkg::ADDR_CCR_TWO:   st_next.rdata = st_reg.channel_control_two;
				smh_pkg::ADDR_TXBC_HIGH: st_next.rdata = st_reg.txbc;
				smh_pkg::ADDR_CFG:       st_next.rdata = st_reg.cfg;
				smh_pkg::ADDR_IRQ_STAT:  st_next.rdata = {6'h00, st_reg.irq_stat};
				smh_pkg::ADDR_IRQ_MASK:  st_next.rdata = st_reg.irq_mask;
				smh_pkg::ADDR_STATUS: begin
					st_next.rdata = {2'h0, st_reg.tx_st, st_reg.rx_on, cd_s,
						cts_ok, st_reg.rts_n};
				end
				default: st_next.rdata = 8'h00;
			endcase
		end

		// clear-to-send change flag, set wins over clear
		if (cts_edge) begin
			st_next.irq_stat[smh_pkg::IRQ_CSC_BIT] = 1'b1;
		end

		// transmit gating
		case (st_reg.tx_st)
			smh_pkg::TX_IDLE: begin
				st_next.pool_gone = 1'b0;
				if (tx_req && cts_ok && !st_reg.rts_hold) begin
					st_next.tx_st = smh_pkg::TX_SEND;
				end
			end
			smh_pkg::TX_SEND: begin
				if (tx_pool_released) begin
					st_next.pool_gone = 1'b1;
				end
				if (!tx_req || tx_frame_end) begin
					st_next.tx_st = smh_pkg::TX_IDLE;
				end else if (!cts_ok) begin
					if (!sync_proto(protocol)) begin
						st_next.tx_st = smh_pkg::TX_DRAIN;
					end else if (st_reg.pool_gone || !tx_frame_held) begin
						st_next.tx_fifo_reset = 1'b1;
						st_next.irq_stat[smh_pkg::IRQ_XMR_BIT] = 1'b1;
						st_next.tx_st = smh_pkg::TX_IDLE;
					end else begin
						st_next.tx_st = smh_pkg::TX_ABORT;
					end
				end
			end
			smh_pkg::TX_ABORT: begin
				if (!tx_frame_held) begin
					st_next.tx_fifo_reset = 1'b1;
					st_next.irq_stat[smh_pkg::IRQ_XMR_BIT] = 1'b1;
					st_next.tx_st = smh_pkg::TX_IDLE;
				end else if (cts_ok) begin
					st_next.tx_restart = 1'b1;
					st_next.tx_st = smh_pkg::TX_SEND;
				end
			end
			smh_pkg::TX_DRAIN: begin
				if (cts_ok) begin
					st_next.tx_st = smh_pkg::TX_SEND;
				end else if (!tx_req) begin
					st_next.tx_st = smh_pkg::TX_IDLE;
				end
			end
			default: begin
				st_next.tx_st = smh_pkg::TX_IDLE;
			end
		endcase

		// transmitter enabled while sending, or finishing a character
		st_next.tx_enable = (st_next.tx_st == smh_pkg::TX_SEND) ||
			((st_next.tx_st == smh_pkg::TX_DRAIN) && !tx_char_end &&
			(st_reg.tx_st != smh_pkg::TX_DRAIN || st_reg.tx_enable));
		st_next.idle_ones = !st_next.tx_enable;

		// request-to-send output

		// repeat keeps request off until transmitter drops it
		if (st_next.tx_fifo_reset) begin
			st_next.rts_hold = 1'b1;
		end else if (!tx_req) begin
			st_next.rts_hold = 1'b0;
		end
		req_pend = tx_req && !st_next.rts_hold;
		soc      = {st_reg.channel_control_two[smh_pkg::CHANNEL_CONTROL_TWO_SOC1_BIT], st_reg.channel_control_two[smh_pkg::CHANNEL_CONTROL_TWO_SOC0_BIT]};
		special  = special_active(st_reg.cfg[smh_pkg::CFG_BUS_BIT], clock_mode);
		if (special && soc == smh_pkg::SOC_OFF) begin
			st_next.rts_n = 1'b1;
		end else if (special && soc == smh_pkg::SOC_RX_ACT) begin
			st_next.rts_n = !rx_frame_active;
		end else if (st_reg.mode[smh_pkg::MODE_RTS_BIT]) begin
			st_next.rts_n = !st_reg.mode[smh_pkg::MODE_RLVL_BIT];
		end else begin
			st_next.rts_n = !req_pend;
		end

		// carrier detect receiver control
		cas_ok = autostart_ok(st_reg.txbc[smh_pkg::TXBC_CAS_BIT], clock_mode);
		if (!cas_ok) begin
			st_next.rx_on = st_reg.mode[smh_pkg::MODE_RAC_BIT] ||
				st_reg.mode == smh_pkg::MODE_RST;
		end else if (cd_s) begin
			st_next.rx_on = 1'b1;
		end else if (rx_byte_end) begin
			st_next.rx_on = 1'b0;
		end

		// local loopback
		st_next.txd = st_reg.mode[smh_pkg::MODE_TLP_BIT] ? 1'b1 :
			(st_next.idle_ones ? 1'b1 : tx_serial);
		st_next.rxd = st_reg.mode[smh_pkg::MODE_TLP_BIT] ?
			(st_next.idle_ones ? 1'b1 : tx_serial) : rxd_pin;

		// power state follows the power-up bit
		st_next.pdn = !st_next.cfg[smh_pkg::CFG_PU_BIT];

		// masked interrupt out
		st_next.irq = |(st_next.irq_stat & ~st_next.irq_mask[1:0]);
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_reg          <= '0;
			st_reg.mode     <= smh_pkg::MODE_RST;
			st_reg.channel_control_two     <= smh_pkg::CHANNEL_CONTROL_TWO_RST;
			st_reg.txbc     <= smh_pkg::TXBC_RST;
			st_reg.cfg      <= smh_pkg::CFG_RST;
			st_reg.irq_mask <= smh_pkg::IRQ_MASK_RST;
			st_reg.tx_st    <= smh_pkg::TX_IDLE;
			st_reg.rts_n    <= 1'b1;
			st_reg.idle_ones <= 1'b1;
			st_reg.txd      <= 1'b1;
			st_reg.rxd      <= 1'b1;
			st_reg.pdn      <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign reg_rdata     = st_reg.rdata;
	assign rts_n         = st_reg.rts_n;
	assign tx_enable     = st_reg.tx_enable;
	assign tx_restart    = st_reg.tx_restart;
	assign tx_fifo_reset = st_reg.tx_fifo_reset;
	assign tx_idle_ones  = st_reg.idle_ones;
	assign txd_out       = st_reg.txd;
	assign rxd_core      = st_reg.rxd;
	assign rx_enable     = st_reg.rx_on;
	assign power_down    = st_reg.pdn;
	assign irq           = st_reg.irq;
endmodule // smh_ctrl

// ---- verification/smh_modem_model.sv ----
// modem model driving clear-to-send and carrier detect
`timescale 1ns/10ps
module smh_modem_model #(
	parameter int LAG = 3
) (
	input  wire logic clk_sys,
	input  wire logic grant,
	input  wire logic carrier,
	output logic      cts_n,
	output logic      cd
);
	// ****************************************
	// delayed answer, off the clock edge
	// ****************************************
	logic [7:0] g_reg = 8'h00;
	logic       cts_q = 1'b1;
	logic       cd_q  = 1'b0;
	always @(posedge clk_sys) begin
		g_reg <= {g_reg[6:0], grant};
		cts_q <= #7 ~g_reg[LAG];
		cd_q <= #13 carrier;
	end
	assign cts_n = cts_q;
	assign cd    = cd_q;
endmodule // smh_modem_model

// ---- verification/smh_ctrl_checker.sv ----
// port checker of the modem handshake controller
`timescale 1ns/10ps
module smh_ctrl_checker (
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       rts_n,
	input wire logic       cts_n,
	input wire logic       tx_req,
	input wire logic       tx_char_end,
	input wire logic       tx_enable,
	input wire logic       tx_restart,
	input wire logic       tx_fifo_reset,
	input wire logic       tx_idle_ones,
	input wire logic       txd_out,
	input wire logic       power_down,
	input wire logic [1:0] protocol
);
	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_reset_idle: assert property (disable iff (1'b0)
		rst |-> rts_n && txd_out && power_down && !tx_enable)
		else $error("outputs not idle in reset");
	a_enable_cause: assert property ($rose(tx_enable) |-> !$past(cts_n, 2))
		else $error("transmit enabled without clear-to-send");
	a_sync_lag: assert property ($fell(cts_n) && !tx_enable |=> !tx_enable)
		else $error("clear-to-send used unsynchronised");
	a_sync_abort: assert property (
		protocol != smh_pkg::PROTO_ASYNC && $rose(cts_n) && tx_enable
		|-> ##[1:6] (!tx_enable && tx_idle_ones))
		else $error("frame not aborted");
	a_restart_cause: assert property (tx_restart
		|-> protocol != smh_pkg::PROTO_ASYNC && !$past(cts_n, 2))
		else $error("restart without clear-to-send");
	a_repeat_rts: assert property (tx_fifo_reset
		|-> rts_n && protocol != smh_pkg::PROTO_ASYNC)
		else $error("fifo reset with request active");
	a_async_hold: assert property (
		protocol == smh_pkg::PROTO_ASYNC && tx_enable && tx_req && !tx_char_end
		|=> tx_enable)
		else $error("character cut short");
	a_idle_out: assert property (tx_idle_ones [*2] |-> txd_out)
		else $error("idle line not ones");
	c_restart: cover property (tx_restart);
	c_repeat: cover property (tx_fifo_reset);
	c_drain: cover property (protocol == smh_pkg::PROTO_ASYNC && $fell(tx_enable));
endmodule // smh_ctrl_checker
bind smh_ctrl smh_ctrl_checker chk_u (.clk_sys, .rst, .rts_n, .cts_n, .tx_req,
	.tx_char_end, .tx_enable, .tx_restart, .tx_fifo_reset, .tx_idle_ones,
	.txd_out, .power_down, .protocol);

// ---- verification/tb.sv ----
// testbench of the modem handshake controller
`timescale 1ns/10ps
`define CK(n, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
	$display("Error %s exp %h got %h", n, e, g); end end
`define WT(c) for (wt = 0; wt < 40 && !(c); wt++) @(negedge clk_sys);
`define PL(s) @(posedge clk_sys) s <= 1'b1; @(posedge clk_sys) s <= 1'b0;
module tb;
	// ****************************************
	// signals and instances
	// ****************************************
	logic       clk_sys = 0, rst = 0, reg_wr = 0, reg_rd = 0;
	logic [3:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, reg_rdata;
	logic       rts_n, cts_n, cd, tx_enable, tx_restart, tx_fifo_reset;
	logic       tx_idle_ones, txd_out, rxd_core, rx_enable, power_down, irq;
	logic       tx_req = 0, tx_char_end = 0, tx_frame_end = 0, tx_pool_released = 0;
	logic       tx_frame_held = 0, tx_serial = 1, rx_frame_active = 0;
	logic       rx_byte_end = 0, rxd_pin = 1, grant = 0, carrier = 0;
	logic [1:0] protocol = 0;
	logic [2:0] clock_mode = 0;
	int         miscompares = 0, n_compared = 0, wt, i;
	always #20 clk_sys = ~clk_sys;
	smh_modem_model mdm_u (.clk_sys, .grant, .carrier, .cts_n, .cd);
	smh_ctrl #(.RESET_CYC(4)) dut_u (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .rts_n, .cts_n, .cd, .tx_req, .tx_char_end,
		.tx_frame_end, .tx_pool_released, .tx_frame_held, .tx_serial, .tx_enable,
		.tx_restart, .tx_fifo_reset, .tx_idle_ones, .txd_out, .rx_frame_active,
		.rx_byte_end, .rxd_pin, .rxd_core, .rx_enable, .protocol, .clock_mode,
		.power_down, .irq);
	// ****************************************
	// tasks
	// ****************************************
	task cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
		@(posedge clk_sys) reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_sys) begin reg_addr <= a; reg_rd <= 1'b1; end
		@(posedge clk_sys) reg_rd <= 1'b0;
		@(negedge clk_sys);
		`CK("rdata", e, reg_rdata)
	endtask
	task chk_reset;
		cyc(1);
		`CK("power_down", 1'b1, power_down)
		`CK("rts_idle", 1'b1, rts_n)
		rd(smh_pkg::ADDR_MODE, 8'h00);
		rd(smh_pkg::ADDR_CCR_TWO, 8'h00);
		rd(smh_pkg::ADDR_TXBC_HIGH, 8'h00);
		rd(smh_pkg::ADDR_IRQ_MASK, 8'hff);
		rd(smh_pkg::ADDR_STATUS, 8'h09);
		rd(4'hf, 8'h00);
	endtask
	task sync_run(input logic [1:0] p, input logic ie);
		@(posedge clk_sys) begin protocol <= p; tx_req <= 1'b1; tx_frame_held <= 1'b1; end
		cyc(3);
		`CK("rts_req", 1'b0, rts_n)
		`CK("wait_cts", 1'b0, tx_enable)
		@(posedge clk_sys) grant <= 1'b1;
		`WT(tx_enable)
		cyc(2);
		`CK("granted", 1'b1, tx_enable)
		`CK("irq", ie, irq)
		@(posedge clk_sys) grant <= 1'b0;
		`WT(!tx_enable)
		cyc(1);
		`CK("abort", 2'b01, {tx_enable, tx_idle_ones})
		`CK("idle_line", 1'b1, txd_out)
		@(posedge clk_sys) grant <= 1'b1;
		`WT(tx_restart)
		`CK("restart", 1'b1, tx_restart)
		`PL(tx_pool_released)
		grant <= 1'b0;
		`WT(tx_fifo_reset)
		`CK("repeat", 2'b11, {tx_fifo_reset, rts_n})
		cyc(2);
		`CK("rts_off_hold", 1'b1, rts_n)
		@(posedge clk_sys) begin tx_req <= 1'b0; tx_frame_held <= 1'b0; end
		rd(smh_pkg::ADDR_IRQ_STAT, 8'h03);
		wr(smh_pkg::ADDR_IRQ_STAT, 8'h03);
		cyc(2);
		`CK("irq_clr", 1'b0, irq)
	endtask
	task wrap_up;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (5000) @(posedge clk_sys);
		miscompares++;
		wrap_up();
	end
	initial begin
		rst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		chk_reset();
		wr(smh_pkg::ADDR_CFG, 8'h40);
		cyc(1);
		`CK("power_up", 1'b0, power_down)
		wr(smh_pkg::ADDR_IRQ_MASK, 8'hfc);
		sync_run(smh_pkg::PROTO_HDLC, 1'b1);
		wr(smh_pkg::ADDR_IRQ_MASK, 8'hff);
		sync_run(smh_pkg::PROTO_BSYNC, 1'b0);
		@(posedge clk_sys) begin protocol <= smh_pkg::PROTO_ASYNC; tx_req <= 1'b1; grant <= 1'b1; end
		`WT(tx_enable)
		@(posedge clk_sys) grant <= 1'b0;
		cyc(12);
		`CK("char_run", 1'b1, tx_enable)
		`PL(tx_char_end)
		cyc(2);
		`CK("char_done", 2'b01, {tx_enable, tx_idle_ones})
		@(posedge clk_sys) grant <= 1'b1;
		`WT(tx_enable)
		`CK("resume", 1'b1, tx_enable)
		@(posedge clk_sys) begin grant <= 1'b0; tx_req <= 1'b0; end
		`PL(tx_char_end)
		wr(smh_pkg::ADDR_MODE, 8'h04);
		cyc(2);
		`CK("sw_rts_high", 1'b1, rts_n)
		wr(smh_pkg::ADDR_MODE, 8'h06);
		cyc(2);
		`CK("sw_rts_low", 1'b0, rts_n)
		wr(smh_pkg::ADDR_MODE, 8'h00);
		wr(smh_pkg::ADDR_CFG, 8'hc0);
		wr(smh_pkg::ADDR_CCR_TWO, 8'h80);
		@(posedge clk_sys) tx_req <= 1'b1;
		cyc(3);
		`CK("rts_off", 1'b1, rts_n)
		@(posedge clk_sys) clock_mode <= smh_pkg::CLK_MODE_5;
		cyc(3);
		`CK("rts_std", 1'b0, rts_n)
		wr(smh_pkg::ADDR_CCR_TWO, 8'hc0);
		@(posedge clk_sys) begin clock_mode <= smh_pkg::CLK_MODE_1; tx_req <= 1'b0; rx_frame_active <= 1'b1; end
		cyc(3);
		`CK("rts_rx", 1'b0, rts_n)
		@(posedge clk_sys) rx_frame_active <= 1'b0;
		cyc(3);
		`CK("rts_rx_end", 1'b1, rts_n)
		wr(smh_pkg::ADDR_CCR_TWO, 8'h00);
		wr(smh_pkg::ADDR_CFG, 8'h40);
		wr(smh_pkg::ADDR_MODE, 8'h02);
		wr(smh_pkg::ADDR_TXBC_HIGH, 8'h04);
		for (i = 0; i < 8; i++) begin
			if (i != 5) begin
				@(posedge clk_sys) begin clock_mode <= 3'(i); carrier <= 1'b1; end
				cyc(8);
				`CK("cd_start", 1'(i != 1), rx_enable)
				@(posedge clk_sys) carrier <= 1'b0;
				cyc(8);
				`CK("cd_byte", 1'(i != 1), rx_enable)
				`PL(rx_byte_end)
				cyc(2);
				`CK("cd_stop", 1'b0, rx_enable)
			end
		end
		wr(smh_pkg::ADDR_MODE, 8'h01);
		@(posedge clk_sys) begin tx_req <= 1'b1; grant <= 1'b1; end
		`WT(tx_enable)
		@(posedge clk_sys) begin tx_serial <= 1'b0; rxd_pin <= 1'b1; end
		cyc(3);
		`CK("loop_rx", 2'b01, {rxd_core, txd_out})
		@(posedge clk_sys) begin tx_serial <= 1'b1; rxd_pin <= 1'b0; end
		cyc(3);
		`CK("loop_rx_one", 1'b1, rxd_core)
		wr(smh_pkg::ADDR_MODE, 8'h00);
		cyc(3);
		`CK("loop_off", 1'b0, rxd_core)
		@(posedge clk_sys) begin tx_req <= 1'b0; grant <= 1'b0; end
		cyc(10);
		@(posedge clk_sys) rst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		chk_reset();
		wrap_up();
	end
endmodule // tb
